// *** src/kbe_encoder.sv ***
// Keypad encoder: digit BCD encoder, function encoder and idle chain
`timescale 1ns/10ps
`default_nettype none
module kbe_encoder
    import kbe_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int DEB_TICKS = DEBOUNCE_TICKS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [KEY_COUNT-1:0] key_n,
    output logic idle_chain_n,
    output kbe_digit_t digit_out,
    output kbe_func_t func_out
);
    generate
        if (TICK_LEN < 2 || TICK_LEN > 1048575) begin : g_bad_tick
            $error("kbe_encoder: TICK_LEN out of range");
        end
        if (DEB_TICKS < 1 || DEB_TICKS > 255) begin : g_bad_deb
            $error("kbe_encoder: DEB_TICKS out of range");
        end
        if (KEY_MEMORY_CLEAR >= KEY_COUNT) begin : g_bad_keys
            $error("kbe_encoder: key map exceeds key count");
        end
    endgenerate

    // ------------------------------------------------------------
    // Debounce tick divider
    // ------------------------------------------------------------
    logic [19:0] tick_count;
    logic [19:0] next_tick_count;
    logic tick;

    // One tick for all keys, so keys pressed together settle together
    always_comb begin
        if (tick_count == 20'(TICK_LEN - 1)) begin
            next_tick_count = 20'h00000;
        end else begin
            next_tick_count = tick_count + 20'h00001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_count <= 20'h00000;
        end else begin
            tick_count <= next_tick_count;
        end
    end

    assign tick = (tick_count == 20'(TICK_LEN - 1));

    // ------------------------------------------------------------
    // Per-key conditioning
    // ------------------------------------------------------------
    logic [KEY_COUNT-1:0] held;

    genvar k;
    generate
        for (k = 0; k < KEY_COUNT; k++) begin : g_key
            kbe_debounce #(.TICKS(DEB_TICKS)) u_deb (
                .clk(clk),
                .rst_b(rst_b),
                .tick(tick),
                .key_raw_n(key_n[k]),
                .pressed(held[k])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Encoding
    // ------------------------------------------------------------
    function automatic logic is_digit_key(input int idx);
        return (idx <= KEY_POINT) || (idx == KEY_CORRECTION);
    endfunction

    // Plain 8-4-2-1 weights; zero and correction carry no weight
    function automatic logic [3:0] weights_of(input int idx);
        logic [3:0] w;
        w = 4'h0;
        if (idx < KEY_ZERO) begin
            w = 4'(idx + 1);
        end else if (idx == KEY_POINT) begin
            w = POINT_WEIGHTS;
        end
        return w;
    endfunction

    kbe_digit_t next_digit;
    kbe_func_t next_func;
    logic next_idle_chain_n;

    // Lowest-numbered held key wins if several are down, so only one input is
    // ever routed; the mechanical chain gave the same exclusivity.
    always_comb begin
        logic [3:0] w;
        w = 4'h0;
        next_digit = DIGIT_IDLE;
        next_func = FUNC_IDLE;
        next_idle_chain_n = |held;
        for (int i = KEY_COUNT - 1; i >= 0; i--) begin
            if (held[i]) begin
                next_digit = DIGIT_IDLE;
                next_func = FUNC_IDLE;
                if (is_digit_key(i)) begin
                    w = weights_of(i);
                    next_digit.present_n = 1'b0;
                    next_digit.w8_n = ~w[3];
                    next_digit.w4_n = ~w[2];
                    next_digit.w2_n = ~w[1];
                    next_digit.w1_n = ~w[0];
                    next_digit.correction_line_n = (i != KEY_CORRECTION);
                end else begin
                    next_func.present_n = 1'b0;
                    next_func.code_n = ~5'(i - FUNC_CODE_BASE);
                    next_func.memory_clear_key_line_n = (i != KEY_MEMORY_CLEAR);
                end
            end
        end
    end

    // Outputs follow the held level one cycle later, so release restores idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_chain_n <= 1'b0;
            digit_out <= DIGIT_IDLE;
            func_out <= FUNC_IDLE;
        end else begin
            idle_chain_n <= next_idle_chain_n;
            digit_out <= next_digit;
            func_out <= next_func;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Patterns assume a single held key; with several, the lowest index shows
    idle_chain_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
        (held == '0) |=> (idle_chain_n == 1'b0))
        else $error("idle chain not low with no key held");

    all_rest_high_a: assert property (@(posedge clk) disable iff (!rst_b)
        (held == '0) |=> (digit_out == DIGIT_IDLE) && (func_out == FUNC_IDLE))
        else $error("outputs not at rest with no key held");

    route_one_side_a: assert property (@(posedge clk) disable iff (!rst_b)
        ($countones(held) == 1) |=>
            idle_chain_n && (digit_out.present_n != func_out.present_n))
        else $error("single key not routed to exactly one encoder");

    active_when_held_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!digit_out.present_n || !func_out.present_n) |-> $past(held != '0))
        else $error("encoder active without a held key");

    release_high_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(|held) |=> digit_out.present_n && func_out.present_n)
        else $error("outputs not high after release");

    digit_three_a: assert property (@(posedge clk) disable iff (!rst_b)
        (held == 32'h00000004) |=>
            (digit_out == kbe_digit_t'{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1}))
        else $error("key 3 pattern wrong");

    digit_eight_a: assert property (@(posedge clk) disable iff (!rst_b)
        (held == 32'h00000080) |=> !digit_out.w8_n && digit_out.w4_n && digit_out.w1_n)
        else $error("key 8 pattern wrong");

    correction_a: assert property (@(posedge clk) disable iff (!rst_b)
        (held == 32'h00020000) |=>
            (digit_out == kbe_digit_t'{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0}))
        else $error("correction pattern wrong");

    point_weights_a: assert property (@(posedge clk) disable iff (!rst_b)
        (held == 32'h00000400) |=>
            (digit_out == kbe_digit_t'{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1}))
        else $error("point pattern wrong");

    zero_weights_a: assert property (@(posedge clk) disable iff (!rst_b)
        (held == 32'h00000200) |=>
            (digit_out == kbe_digit_t'{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1}))
        else $error("zero pattern wrong");

    digit_nine_a: assert property (@(posedge clk) disable iff (!rst_b)
        (held == 32'h00000100) |=>
            (digit_out == kbe_digit_t'{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1}))
        else $error("key 9 pattern wrong");

    function_key_a: assert property (@(posedge clk) disable iff (!rst_b)
        (held == 32'h80000000) |=> !func_out.present_n
            && !func_out.memory_clear_key_line_n && digit_out.present_n)
        else $error("function key not encoded");

    lowest_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
        (held == 32'h00100004) |=> !digit_out.present_n && func_out.present_n)
        else $error("lower key did not win");

    one_encoder_a: assert property (@(posedge clk) disable iff (!rst_b)
        digit_out.present_n || func_out.present_n)
        else $error("both encoders active");

    chain_follows_a: assert property (@(posedge clk) disable iff (!rst_b)
        idle_chain_n == (!digit_out.present_n || !func_out.present_n))
        else $error("idle chain disagrees with encoders");

    digit_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
        digit_out.present_n |-> (digit_out == DIGIT_IDLE))
        else $error("digit lines low without present");

    func_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
        func_out.present_n |-> (func_out == FUNC_IDLE))
        else $error("function lines low without present");

    tick_single_a: assert property (@(posedge clk) disable iff (!rst_b)
        tick |=> !tick)
        else $error("debounce tick longer than one cycle");

endmodule
`default_nettype wire

// *** src/kbe_pkg.sv ***
// Constants and carrier types of the keypad encoder
//
// Functional notes
// - Idle chain passes the active-low common level while no key is held.
// - With all keys at rest every digit and function output rests high.
// - A held key moves the common level off the idle chain onto its own input.
// - Each of 32 key lines is active only while its contact is switched.
// - Outputs go low with their key and return high on release.
// - Digit keys appear as active-low 8-4-2-1 weight lines.
// - Key 3 drives present, weight-1, weight-2 low; the rest stay high.
// - Digits, point and correction drive present low; correction also its own line.
// - Point drives weight-4 and weight-8 low; zero leaves weights high; 8, 9 drive weight-8.
// - Function encoder behaves alike: active-low inputs, active-low codes, idle high.
package kbe_pkg;

    localparam int KEY_COUNT = 32;
    localparam int CLK_PERIOD_NS = 50;
    // ------------------------------------------------------------
    // Debounce timing
    // ------------------------------------------------------------
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEBOUNCE_TICKS = 4;
    // ------------------------------------------------------------
    // Key positions on the 32-line keyboard
    // ------------------------------------------------------------
    localparam int KEY_ZERO = 9;
    localparam int KEY_POINT = 10;
    localparam int KEY_CORRECTION = 17;
    localparam int KEY_MEMORY_CLEAR = 31;
    localparam int FUNC_CODE_BASE = 10;
    localparam logic [3:0] POINT_WEIGHTS = 4'hc;

    typedef struct packed {
        logic present_n;
        logic w8_n;
        logic w4_n;
        logic w2_n;
        logic w1_n;
        logic correction_line_n;
    } kbe_digit_t;

    typedef struct packed {
        logic present_n;
        logic [4:0] code_n;
        logic memory_clear_key_line_n;
    } kbe_func_t;

    localparam kbe_digit_t DIGIT_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    localparam kbe_func_t FUNC_IDLE = '{1'b1, 5'h1f, 1'b1};

endpackage

// *** src/kbe_debounce.sv ***
// One key line: synchroniser and tick-based debounce
`timescale 1ns/10ps
`default_nettype none
module kbe_debounce
    import kbe_pkg::*;
#(
    parameter int TICKS = DEBOUNCE_TICKS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic key_raw_n,
    output logic pressed
);
    generate
        if (TICKS < 1 || TICKS > 255) begin : g_bad
            $error("kbe_debounce: TICKS out of range");
        end
    endgenerate

    logic sync1_n;
    logic sync2_n;
    logic [7:0] count;
    logic [7:0] next_count;
    logic next_pressed;

    // Contact must stay changed across TICKS tick pulses before it counts; the first pulse may come in the same cycle the synchronised level changes
    always_comb begin
        next_count = count;
        next_pressed = pressed;
        if ((~sync2_n) == pressed) begin
            next_count = 8'h00;
        end else if (tick) begin
            if (count == 8'(TICKS - 1)) begin
                next_pressed = ~sync2_n;
                next_count = 8'h00;
            end else begin
                next_count = count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_n <= 1'b1;
            sync2_n <= 1'b1;
            count <= 8'h00;
            pressed <= 1'b0;
        end else begin
            sync1_n <= key_raw_n;
            sync2_n <= sync1_n;
            count <= next_count;
            pressed <= next_pressed;
        end
    end

    debounce_on_tick_a: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(pressed) |-> $past(tick))
        else $error("debounced level moved without a tick");

endmodule
`default_nettype wire

// *** bench/kbe_alu_model.sv ***
// Behavioural arithmetic unit that consumes the encoded key lines
`timescale 1ns/10ps
`default_nettype none
module kbe_alu_model
    import kbe_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire kbe_digit_t digit_out,
    input wire kbe_func_t func_out,
    output var int strokes,
    output logic [3:0] last_digit
);
    logic was_active;
    logic active;
    assign active = !digit_out.present_n || !func_out.present_n;
    // One stroke per press; a held key must not be taken twice
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            was_active <= 1'b0;
            strokes <= 0;
            last_digit <= 4'h0;
        end else begin
            was_active <= active;
            if (active && !was_active) begin
                strokes <= strokes + 1;
                if (!digit_out.present_n) begin
                    last_digit <= ~{digit_out.w8_n, digit_out.w4_n, digit_out.w2_n,
                                    digit_out.w1_n};
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the keypad encoder
`timescale 1ns/10ps
`default_nettype none
module tb
    import kbe_pkg::*;
;
    logic clk;
    logic rst_b;
    logic [KEY_COUNT-1:0] key_n;
    logic idle_chain_n;
    kbe_digit_t digit_out;
    kbe_func_t func_out;
    int err_count;
    int compares;
    int strokes;
    int presses;
    logic [3:0] last_digit;
    kbe_encoder #(.TICK_LEN(4), .DEB_TICKS(2)) DUT (.clk(clk), .rst_b(rst_b),
        .key_n(key_n), .idle_chain_n(idle_chain_n), .digit_out(digit_out),
        .func_out(func_out));
    kbe_alu_model alu (.clk(clk), .rst_b(rst_b), .digit_out(digit_out),
        .func_out(func_out), .strokes(strokes), .last_digit(last_digit));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic results();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [6:0] seen, input logic [6:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, seen, exp);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #5;
    endtask
    // Bounded wait for the idle chain; worst debounce is well under 40 cycles
    task automatic wait_idle(input logic lvl);
        int n;
        for (n = 0; n < 40 && idle_chain_n !== lvl; n++) step();
        if (idle_chain_n !== lvl) begin
            check(7'(idle_chain_n), 7'(lvl), "idle chain wait");
            results();
        end
    endtask
    function automatic kbe_digit_t dexp(input logic [3:0] w, input logic c);
        return {1'b0, ~w, c};
    endfunction
    task automatic press(input int idx, input kbe_digit_t d, input kbe_func_t f);
        key_n[idx] = 1'b0;
        wait_idle(1'b1);
        presses++;
        check({1'b0, digit_out}, {1'b0, d}, "digit lines");
        check(func_out, f, "function lines");
        key_n = '1;
        wait_idle(1'b0);
        check({1'b0, digit_out}, {1'b0, DIGIT_IDLE}, "digit release");
        check(func_out, FUNC_IDLE, "function release");
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check(7'(idle_chain_n), 7'h0, "idle chain at rest");
        check({1'b0, digit_out}, {1'b0, DIGIT_IDLE}, "digit idle");
        check(func_out, FUNC_IDLE, "function idle");
    endtask
    task automatic t_digits();
        press(2, dexp(4'h3, 1'b1), FUNC_IDLE);
        for (int i = 0; i < 9; i++) press(i, dexp(4'(i + 1), 1'b1), FUNC_IDLE);
        press(KEY_ZERO, dexp(4'h0, 1'b1), FUNC_IDLE);
        press(KEY_POINT, dexp(POINT_WEIGHTS, 1'b1), FUNC_IDLE);
        press(KEY_CORRECTION, dexp(4'h0, 1'b0), FUNC_IDLE);
    endtask
    task automatic t_funcs();
        for (int i = 11; i < KEY_COUNT; i++) begin
            if (i != KEY_CORRECTION) begin
                press(i, DIGIT_IDLE, {1'b0, ~5'(i - FUNC_CODE_BASE),
                      1'(i != KEY_MEMORY_CLEAR)});
            end
        end
    endtask
    // A contact chatter of two cycles is shorter than one debounce window
    task automatic t_bounce();
        logic seen;
        seen = 1'b0;
        key_n[4] = 1'b0;
        step();
        step();
        key_n = '1;
        repeat (30) begin
            step();
            if (idle_chain_n !== 1'b0) seen = 1'b1;
        end
        check(7'(seen), 7'h0, "bounce reached outputs");
    endtask
    // Keys 3 and a function key fall together; the lower index must win
    task automatic t_two_keys();
        key_n = ~32'h00100004;
        wait_idle(1'b1);
        presses++;
        check({1'b0, digit_out}, {1'b0, dexp(4'h3, 1'b1)}, "two keys digit");
        check(func_out, FUNC_IDLE, "two keys function");
        key_n = '1;
        wait_idle(1'b0);
        check(7'(last_digit), 7'h3, "partner digit");
        check(7'(strokes), 7'(presses), "stroke count");
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rst_b = 1'b0;
        key_n = '1;
        err_count = 0;
        compares = 0;
        presses = 0;
        repeat (6) @(posedge clk);
        #5;
        rst_b = 1'b1;
        step();
        t_reset();
        t_digits();
        t_funcs();
        t_bounce();
        t_two_keys();
        results();
    end
endmodule
`default_nettype wire
